/* File: shared/pio_cfg.svh */
// Constants of the parallel I/O port bank: register indices, masks, codes.
// Included by the package and the design files; holds definitions only.
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// Register indices; byte address is four times the index
`define PIO_IDX_P5_DIR   30'h0000ffb8
`define PIO_IDX_P6_DIR   30'h0000ffb9
`define PIO_IDX_P5_LAT   30'h0000ffba
`define PIO_IDX_P6_LAT   30'h0000ffbb
`define PIO_IDX_P8_DIR   30'h0000ffbd
`define PIO_IDX_P7_PIN   30'h0000ffbe
`define PIO_IDX_P8_LAT   30'h0000ffbf
`define PIO_IDX_P9_DIR   30'h0000ffc0
`define PIO_IDX_P9_LAT   30'h0000ffc1

// Reserved bits read as one; write-only registers read as all ones
`define PIO_P5_RSV       8'hf8
`define PIO_P8_RSV       8'h80
`define PIO_WO_READ      8'hff
`define PIO_RST_VAL      8'h00
`define PIO_P9_PIN6      3'h6

// Operating mode codes
`define PIO_MODE_1       2'h1
`define PIO_MODE_2       2'h2

// AXI responses
`define PIO_RESP_OKAY    2'h0
`define PIO_RESP_SLVERR  2'h2

`endif

/* File: shared/pio_pkg.sv */
// Types shared by the port bank and its bus slave.
// Assumes pio_cfg.svh sits on the include path.
`include "pio_cfg.svh"
package pio_pkg;
  typedef logic [7:0] pio_byte_t;
  typedef enum logic [3:0]
  {
    PIO_SEL_NONE   = 4'b0000,
    PIO_SEL_P5_DIR = 4'b0001,
    PIO_SEL_P6_DIR = 4'b0010,
    PIO_SEL_P5_LAT = 4'b0011,
    PIO_SEL_P6_LAT = 4'b0100,
    PIO_SEL_P8_DIR = 4'b0101,
    PIO_SEL_P7_PIN = 4'b0110,
    PIO_SEL_P8_LAT = 4'b0111,
    PIO_SEL_P9_DIR = 4'b1000,
    PIO_SEL_P9_LAT = 4'b1001
  } pio_sel_t;
endpackage

/* File: tb/tb_top.sv */
// Self-checking bench for the port bank: AXI4-Lite master tasks, pin drive and a response scoreboard.
// Assumes pio_bank and pio_pkg compiled first and pio_cfg.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pio_cfg.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import pio_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mode_sel, m;
  logic [2:0]  p5_in, p5_out, p5_oe;
  logic [6:0]  p8_in, p8_out, p8_oe;
  pio_byte_t   p6_in, p6_out, p6_oe, p7_in, p9_in, p9_out, p9_oe, d, e;
  logic [33:0] rq[$];
  logic [33:0] got;
  logic [1:0]  bq[$];
  int          num_errors = 0;
  int          num_checks = 0;
  int          seed = 2542;
  int          i;

  pio_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mode_sel(mode_sel),
    .p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p6_pin_in(p6_in), .p6_pin_out(p6_out),
    .p6_pin_oe(p6_oe), .p7_pin_in(p7_in), .p8_pin_in(p8_in), .p8_pin_out(p8_out), .p8_pin_oe(p8_oe),
    .p9_pin_in(p9_in), .p9_pin_out(p9_out), .p9_pin_oe(p9_oe));

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [31:0] ba(input logic [29:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic end_of_test();
    if (rq.size() != 0 || bq.size() != 0)
      num_errors++;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timed_out();
    num_errors++;
    $display("Error bus wait limit used up");
    end_of_test();
  endtask

  // Both address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input pio_byte_t v, input logic [3:0] s, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, v};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // Some writes hold bready back until bvalid shows, so the response must wait
    bready  <= 1'($random(seed));
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1)
        bready <= 1'b1;
      n++;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 40);
    bready <= 1'b0;
    if (n >= 40)
      timed_out();
  endtask

  task automatic rd(input logic [31:0] a, input pio_byte_t v, input logic [1:0] r);
    int n;
    rq.push_back({r, 24'h000000, v});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (n >= 40)
      timed_out();
  endtask

  // Scoreboard: oldest note against each response handshake
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      got = (rq.size() != 0) ? rq.pop_front() : 34'h3ffffffff;
      `CHK("read resp/data", got, {rresp, rdata})
    end
    if (bvalid === 1'b1 && bready === 1'b1)
    begin
      got[1:0] = (bq.size() != 0) ? bq.pop_front() : 2'h3;
      `CHK("bresp", got[1:0], bresp)
    end
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr, wstrb} = 100'h0;
    {p5_in, p6_in, p7_in, p8_in, p9_in} = $random(seed);
    mode_sel = `PIO_MODE_1;
    aresetn  = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("p9_oe reset", 8'h40, p9_oe)
    `CHK("p8_oe reset", 7'h00, p8_oe)
    `CHK("p8_out reset", 7'h00, p8_out)
    `CHK("p6 reset", 16'h0000, {p6_oe, p6_out})
    `CHK("p9_out reset", 8'h00, p9_out)
    rd(ba(`PIO_IDX_P8_LAT), 8'h80, `PIO_RESP_OKAY);
    rd(ba(`PIO_IDX_P8_DIR), `PIO_WO_READ, `PIO_RESP_OKAY);
    rd(ba(`PIO_IDX_P9_LAT), {1'b0, p9_in[6], 6'h00}, `PIO_RESP_OKAY);
    mode_sel <= 2'h3;
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      e = $random(seed);
      {p5_in, p6_in, p7_in, p8_in, p9_in} <= $random(seed);
      wr(ba(`PIO_IDX_P6_DIR), d, 4'h1, `PIO_RESP_OKAY);
      wr(ba(`PIO_IDX_P6_LAT), e, 4'hf, `PIO_RESP_OKAY);
      `CHK("p6_oe", d, p6_oe)
      `CHK("p6_out", e, p6_out)
      rd(ba(`PIO_IDX_P6_LAT), e, `PIO_RESP_OKAY);
      wr(ba(`PIO_IDX_P8_DIR), d, 4'h1, `PIO_RESP_OKAY);
      wr(ba(`PIO_IDX_P8_LAT), e, 4'h1, `PIO_RESP_OKAY);
      `CHK("p8_oe", d[6:0], p8_oe)
      `CHK("p8_out", e[6:0], p8_out)
      rd(ba(`PIO_IDX_P8_LAT), {1'b1, e[6:0]}, `PIO_RESP_OKAY);
      wr(ba(`PIO_IDX_P7_PIN), d, 4'h1, `PIO_RESP_OKAY);
      rd(ba(`PIO_IDX_P7_PIN), p7_in, `PIO_RESP_OKAY);
      wr(ba(`PIO_IDX_P9_LAT), e, 4'h1, `PIO_RESP_OKAY);
      rd(ba(`PIO_IDX_P9_LAT), {e[7], p9_in[6], e[5:0]}, `PIO_RESP_OKAY);
      `CHK("p9_out", {e[7], 1'b0, e[5:0]}, p9_out)
      wr(ba(`PIO_IDX_P5_DIR), d, 4'h1, `PIO_RESP_OKAY);
      wr(ba(`PIO_IDX_P5_LAT), e, 4'h1, `PIO_RESP_OKAY);
      `CHK("p5 pins", {d[2:0], e[2:0]}, {p5_oe, p5_out})
      rd(ba(`PIO_IDX_P5_LAT), `PIO_P5_RSV | e, `PIO_RESP_OKAY);
    end
    // Mode table: mode, value written to port 9 direction, expected enables
    for (i = 0; i < 5; i++)
    begin
      {m, d, e} = {18'h30000, 18'h10040, 18'h23f7f, 18'h00f0f, 18'h34040} >> (18 * (4 - i));
      mode_sel <= m;
      wr(ba(`PIO_IDX_P9_DIR), d, 4'h1, `PIO_RESP_OKAY);
      `CHK("p9_oe mode", e, p9_oe)
    end
    // Unmapped, misaligned and lane-0-off writes leave state alone
    wr(ba(30'h0000ffbc), 8'h55, 4'h1, `PIO_RESP_SLVERR);
    rd(ba(30'h0000ffbc), 8'h00, `PIO_RESP_SLVERR);
    wr(ba(`PIO_IDX_P6_LAT) + 32'h1, 8'h5a, 4'h1, `PIO_RESP_SLVERR);
    rd(ba(`PIO_IDX_P6_LAT) + 32'h2, 8'h00, `PIO_RESP_SLVERR);
    wr(ba(`PIO_IDX_P6_LAT), 8'h3c, 4'h1, `PIO_RESP_OKAY);
    wr(ba(`PIO_IDX_P6_LAT), 8'hc3, 4'he, `PIO_RESP_OKAY);
    rd(ba(`PIO_IDX_P6_LAT), 8'h3c, `PIO_RESP_OKAY);
    // Second reset in mode 3 clears every direction bit
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("oe after reset", 15'h0000, {p6_oe, p8_oe})
    `CHK("p9_oe mode 3 reset", 8'h00, p9_oe)
    rd(ba(`PIO_IDX_P8_LAT), 8'h80, `PIO_RESP_OKAY);
    repeat (2) @(posedge aclk);
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: verilog/pio_axil_slave.sv */
// AXI4-Lite slave front end for the port bank: one write and one read in flight.
// Assumes the bank decodes addresses and returns read data combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "pio_cfg.svh"
module pio_axil_slave
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write channels
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read channels
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Bank side
  output logic                   wr_fire,
  output logic [31:0]            wr_addr,
  output pio_pkg::pio_byte_t     wr_data,
  output logic                   wr_lane0,
  input  wire logic              wr_ok,
  output logic                   ar_fire,
  input  wire pio_pkg::pio_byte_t rd_data,
  input  wire logic              rd_ok
);
  import pio_pkg::*;

  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt, lane0_r, lane0_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] waddr_r, waddr_nxt;
  pio_byte_t   wdata_r, wdata_nxt, rdata_r, rdata_nxt;

  // Both halves held and no response pending
  assign wr_fire  = !awready_r && !wready_r && !bvalid_r;
  assign ar_fire  = s_axi_arvalid && arready_r;
  assign wr_addr  = waddr_r;
  assign wr_data  = wdata_r;
  assign wr_lane0 = lane0_r;

  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    lane0_nxt   = lane0_r;
    if (s_axi_awvalid && awready_r)
    begin
      awready_nxt = 1'b0;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      wready_nxt = 1'b0;
      wdata_nxt  = s_axi_wdata[7:0];
      lane0_nxt  = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (ar_fire)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = rd_data;
      rresp_nxt   = rd_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (!aresetn)
    begin
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
      bvalid_nxt  = 1'b0;
      bresp_nxt   = `PIO_RESP_OKAY;
      arready_nxt = 1'b1;
      rvalid_nxt  = 1'b0;
      rresp_nxt   = `PIO_RESP_OKAY;
      rdata_nxt   = `PIO_RST_VAL;
      waddr_nxt   = 32'h0;
      wdata_nxt   = `PIO_RST_VAL;
      lane0_nxt   = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    awready_r <= awready_nxt;
    wready_r  <= wready_nxt;
    bvalid_r  <= bvalid_nxt;
    bresp_r   <= bresp_nxt;
    arready_r <= arready_nxt;
    rvalid_r  <= rvalid_nxt;
    rresp_r   <= rresp_nxt;
    rdata_r   <= rdata_nxt;
    waddr_r   <= waddr_nxt;
    wdata_r   <= wdata_nxt;
    lane0_r   <= lane0_nxt;
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h0, rdata_r};
endmodule
`default_nettype wire

/* File: verilog/pio_bank.sv */
// Parallel I/O port bank, ports 5 to 9, with an AXI4-Lite register slave.
// Assumes pins are synchronous to aclk and an outside pad resolves in/out/oe.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pio_cfg.svh"
module pio_bank
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Operating mode
  input  wire logic [1:0]        mode_sel,
  // Port 5, three pins
  input  wire logic [2:0]        p5_pin_in,
  output logic [2:0]             p5_pin_out,
  output logic [2:0]             p5_pin_oe,
  // Port 6
  input  wire pio_pkg::pio_byte_t p6_pin_in,
  output pio_pkg::pio_byte_t     p6_pin_out,
  output pio_pkg::pio_byte_t     p6_pin_oe,
  // Port 7, input only
  input  wire pio_pkg::pio_byte_t p7_pin_in,
  // Port 8, seven pins
  input  wire logic [6:0]        p8_pin_in,
  output logic [6:0]             p8_pin_out,
  output logic [6:0]             p8_pin_oe,
  // Port 9
  input  wire pio_pkg::pio_byte_t p9_pin_in,
  output pio_pkg::pio_byte_t     p9_pin_out,
  output pio_pkg::pio_byte_t     p9_pin_oe
);
  import pio_pkg::*;

  function automatic pio_sel_t pio_decode(input logic [31:0] addr);
    pio_sel_t sel;
    sel = PIO_SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      unique case (addr[31:2])
        `PIO_IDX_P5_DIR: sel = PIO_SEL_P5_DIR;
        `PIO_IDX_P6_DIR: sel = PIO_SEL_P6_DIR;
        `PIO_IDX_P5_LAT: sel = PIO_SEL_P5_LAT;
        `PIO_IDX_P6_LAT: sel = PIO_SEL_P6_LAT;
        `PIO_IDX_P8_DIR: sel = PIO_SEL_P8_DIR;
        `PIO_IDX_P7_PIN: sel = PIO_SEL_P7_PIN;
        `PIO_IDX_P8_LAT: sel = PIO_SEL_P8_LAT;
        `PIO_IDX_P9_DIR: sel = PIO_SEL_P9_DIR;
        `PIO_IDX_P9_LAT: sel = PIO_SEL_P9_LAT;
        default:         sel = PIO_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  logic        wr_fire, wr_lane0, ar_fire, mode12;
  logic [31:0] wr_addr;
  pio_byte_t   wr_data, rd_data;
  pio_sel_t    wr_sel, rd_sel;
  logic [2:0]  p5_dir_r, p5_dir_nxt, p5_lat_r, p5_lat_nxt;
  pio_byte_t   p6_dir_r, p6_dir_nxt, p6_lat_r, p6_lat_nxt;
  logic [6:0]  p8_dir_r, p8_dir_nxt, p8_lat_r, p8_lat_nxt;
  pio_byte_t   p9_dir_r, p9_dir_nxt, p9_lat_r, p9_lat_nxt;

  pio_axil_slave u_slave
  (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_fire       (wr_fire),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_lane0      (wr_lane0),
    .wr_ok         (wr_sel != PIO_SEL_NONE),
    .ar_fire       (ar_fire),
    .rd_data       (rd_data),
    .rd_ok         (rd_sel != PIO_SEL_NONE)
  );

  assign wr_sel = pio_decode(wr_addr);
  assign rd_sel = pio_decode(s_axi_araddr);
  assign mode12 = (mode_sel == `PIO_MODE_1) || (mode_sel == `PIO_MODE_2);

  // Read mux; direction registers are write-only and read as ones
  always_comb
  begin
    rd_data = `PIO_WO_READ;
    unique case (rd_sel)
      PIO_SEL_P5_LAT: rd_data = `PIO_P5_RSV | {5'h00, p5_lat_r};
      PIO_SEL_P6_LAT: rd_data = p6_lat_r;
      PIO_SEL_P7_PIN: rd_data = p7_pin_in;
      PIO_SEL_P8_LAT: rd_data = `PIO_P8_RSV | {1'b0, p8_lat_r};
      PIO_SEL_P9_LAT: rd_data = {p9_lat_r[7], p9_pin_in[6], p9_lat_r[5:0]};
      PIO_SEL_NONE:   rd_data = `PIO_RST_VAL;
      default:        rd_data = `PIO_WO_READ;
    endcase
  end

  // Register writes; only byte lane 0 carries the 8-bit registers
  always_comb
  begin
    p5_dir_nxt = p5_dir_r;
    p5_lat_nxt = p5_lat_r;
    p6_dir_nxt = p6_dir_r;
    p6_lat_nxt = p6_lat_r;
    p8_dir_nxt = p8_dir_r;
    p8_lat_nxt = p8_lat_r;
    p9_dir_nxt = p9_dir_r;
    p9_lat_nxt = p9_lat_r;
    if (wr_fire && wr_lane0)
    begin
      unique case (wr_sel)
        PIO_SEL_P5_DIR: p5_dir_nxt = wr_data[2:0];
        PIO_SEL_P5_LAT: p5_lat_nxt = wr_data[2:0];
        PIO_SEL_P6_DIR: p6_dir_nxt = wr_data;
        PIO_SEL_P6_LAT: p6_lat_nxt = wr_data;
        PIO_SEL_P8_DIR: p8_dir_nxt = wr_data[6:0];
        PIO_SEL_P8_LAT: p8_lat_nxt = wr_data[6:0];
        PIO_SEL_P9_DIR: p9_dir_nxt = wr_data;
        PIO_SEL_P9_LAT: p9_lat_nxt = wr_data;
        default:        p5_dir_nxt = p5_dir_r;
      endcase
    end
    // Bit 6 of port 9 data is pin-only; its latch stays clear
    p9_lat_nxt[`PIO_P9_PIN6] = 1'b0;
    // Reset is synchronous, so the mode may steer the reset value
    if (!aresetn)
    begin
      p5_dir_nxt = 3'(`PIO_RST_VAL);
      p5_lat_nxt = 3'(`PIO_RST_VAL);
      p6_dir_nxt = `PIO_RST_VAL;
      p6_lat_nxt = `PIO_RST_VAL;
      p8_dir_nxt = 7'(`PIO_RST_VAL);
      p8_lat_nxt = 7'(`PIO_RST_VAL);
      p9_dir_nxt = `PIO_RST_VAL;
      p9_lat_nxt = `PIO_RST_VAL;
    end
    if (mode12)
    begin
      p9_dir_nxt[`PIO_P9_PIN6] = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    p5_dir_r <= p5_dir_nxt;
    p5_lat_r <= p5_lat_nxt;
    p6_dir_r <= p6_dir_nxt;
    p6_lat_r <= p6_lat_nxt;
    p8_dir_r <= p8_dir_nxt;
    p8_lat_r <= p8_lat_nxt;
    p9_dir_r <= p9_dir_nxt;
    p9_lat_r <= p9_lat_nxt;
  end

  // Pins take latch and direction straight from the flops
  assign p5_pin_out = p5_lat_r;
  assign p5_pin_oe  = p5_dir_r;
  assign p6_pin_out = p6_lat_r;
  assign p6_pin_oe  = p6_dir_r;
  assign p8_pin_out = p8_lat_r;
  assign p8_pin_oe  = p8_dir_r;
  assign p9_pin_out = p9_lat_r;
  assign p9_pin_oe  = p9_dir_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic p6_dir_wr;
  assign p6_dir_wr = wr_fire && wr_lane0 && (wr_sel == PIO_SEL_P6_DIR);

  chk_dir_drives_oe: assert property (
    p6_dir_wr |=> (p6_pin_oe == $past(wr_data)) && (p6_pin_out == $past(p6_lat_r)))
    else $error("port 6 direction write did not reach the enables");
  chk_p8_dir_read: assert property (
    (ar_fire && rd_sel == PIO_SEL_P8_DIR) |=> s_axi_rvalid && s_axi_rdata[7:0] == `PIO_WO_READ)
    else $error("port 8 direction read did not return ones");
  chk_p7_live_read: assert property (
    (ar_fire && rd_sel == PIO_SEL_P7_PIN) |=> s_axi_rdata[7:0] == $past(p7_pin_in))
    else $error("port 7 read did not return pin levels");
  chk_p9_pin6_read: assert property (
    (ar_fire && rd_sel == PIO_SEL_P9_LAT) |=> s_axi_rdata[6] == $past(p9_pin_in[6]) && !p9_pin_out[6])
    else $error("port 9 bit 6 read did not follow its pin");
  chk_p8_lat_read: assert property (
    (ar_fire && rd_sel == PIO_SEL_P8_LAT) |=> s_axi_rdata[7:0] == {1'b1, $past(p8_pin_out)})
    else $error("port 8 data read wrong");
  chk_p9_dir6_fixed: assert property (
    (mode12 && $past(mode12)) |-> p9_pin_oe[6])
    else $error("port 9 direction bit 6 not held in modes 1 and 2");
  chk_read_latency: assert property (
    ar_fire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  chk_write_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");

  cov_p6_dir_write: cover property (p6_dir_wr ##1 p6_pin_oe != 8'h00);
  cov_p7_read:      cover property (ar_fire && rd_sel == PIO_SEL_P7_PIN);
  cov_bad_addr:     cover property (wr_fire && wr_sel == PIO_SEL_NONE);
endmodule
`default_nettype wire
